// [common/x25lp_pkg.sv]
// Purpose: Shared constants and carriers for the X.25 link parameter timers.
// Assumes: APB slave with 32-bit data, 8-bit byte address, 40 MHz clock.
// Notes: All time parameters count 100 ms units.
package x25lp_pkg;

    // Clock and timer unit.
    localparam int X25LP_CLK_HZ = 40_000_000;
    localparam int X25LP_UNIT_MS = 100;
    localparam int X25LP_UNIT_CYCLES = X25LP_CLK_HZ / 1000 * X25LP_UNIT_MS;
    localparam int X25LP_PRE_W = 23;

    // Register byte offsets.
    localparam logic [7:0] X25LP_A_CMD = 8'h00;
    localparam logic [7:0] X25LP_A_ADDR = 8'h04;
    localparam logic [7:0] X25LP_A_NEXT = 8'h08;
    localparam logic [7:0] X25LP_A_STATUS = 8'h0c;
    localparam logic [7:0] X25LP_A_STAGE = 8'h10;
    localparam logic [7:0] X25LP_A_ACTIVE = 8'h20;
    localparam logic [7:0] X25LP_A_LIMIT = 8'h30;

    // Command word layout and command codes.
    localparam int X25LP_CMD_CD_BIT = 8;
    localparam logic [7:0] X25LP_OP_BRANCH = 8'h08;
    localparam logic [7:0] X25LP_OP_SETMODE = 8'h23;
    localparam int X25LP_ADDR_W = 24;

    // Line parameter block.
    localparam int X25LP_NPARAM = 13;
    localparam int X25LP_P_TP = 0;
    localparam int X25LP_P_FP = 1;
    localparam int X25LP_P_CP = 2;
    localparam int X25LP_P_INB = 3;
    localparam int X25LP_P_DSR = 4;
    localparam int X25LP_P_N2 = 5;
    localparam int X25LP_P_MAXH = 6;
    localparam int X25LP_P_MAXL = 7;
    localparam logic [7:0] X25LP_PRM_RESET = 8'h01;

    // Status bits; all bits are write-one-to-clear.
    localparam int X25LP_STAT_W = 9;
    localparam int X25LP_S_REJECT = 0;
    localparam int X25LP_S_LOADED = 1;
    localparam int X25LP_S_RESP_ERR = 2;
    localparam int X25LP_S_UNACK_ERR = 3;
    localparam int X25LP_S_IFIELD_ERR = 4;
    localparam int X25LP_S_UNIT_CHECK = 5;
    localparam int X25LP_S_INACTIVE = 6;
    localparam int X25LP_S_DISC = 7;
    localparam int X25LP_S_DONE = 8;

    // Timer slots.
    localparam int X25LP_NTIMER = 3;
    localparam int X25LP_T_RESP = 0;
    localparam int X25LP_T_INB = 1;
    localparam int X25LP_T_DSR = 2;

    typedef struct packed {
        logic tx_poll_sent;
        logic rx_response;
        logic iframe_resent;
        logic rx_ack;
        logic rx_frame_ok;
        logic bufs_returned;
        logic [15:0] rx_ifield_len;
    } x25lp_link_ev_t;

    typedef struct packed {
        logic resend_cmd;
        logic send_frmr_disc;
        logic inbound_flush;
        logic link_disconnect;
        logic link_inactive;
        logic stop_programs;
    } x25lp_link_act_t;

    typedef enum logic [1:0] {
        X25LP_RS_IDLE = 2'b01,
        X25LP_RS_WAIT = 2'b10
    } x25lp_resp_state_t;

endpackage

// [verilog/x25lp_timer.sv]
// Purpose: One down-counting interval timer driven by a 100 ms tick.
// Assumes: Tick is a one-cycle pulse on the same clock.
// Notes: A load of zero expires at the first tick.
`timescale 1ns/1ps
module x25lp_timer
    import x25lp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic stop,
    input wire logic tick,
    input wire logic [7:0] load,
    output logic running,
    output logic expire
);
    logic [7:0] count;

    // Start wins over stop so a restart in an expiry cycle is never lost.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= 8'h00;
            running <= 1'b0;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (start) begin
                count <= load; // RL20
                running <= 1'b1;
            end else if (stop) begin
                running <= 1'b0;
            end else if (running && tick) begin
                if (count <= 8'h01) begin
                    running <= 1'b0;
                    expire <= 1'b1;
                end else begin
                    count <= count - 8'h01;
                end
            end
        end
    end
endmodule // x25lp_timer

// [verilog/x25lp_core.sv]
// Purpose: Command handling and X.25 link parameter timers behind APB.
// Assumes: Link events arrive as same-clock pulses; data set ready is a pin.
// Notes: Parameters are staged over APB and made active by the setmode code.
// Notes on behaviour
// [RL1] Branch makes data address the next command word
// [RL2] Host programs branch back to their start
// [RL3] Line-parameter command loads thirteen parameter bytes
// [RL4] Host loads parameters before starting link control
// [RL5] Parameters hold until the next load
// [RL6] Reject load without pool or with chain-data
// [RL7] Byte 0 sets response timeout
// [RL8] Polls, mode set and disconnect start timer
// [RL9] Restart timer per factor, then resend frame
// [RL10] Byte 1 sets expiries before each resend
// [RL11] Byte 2 sets number of resends
// [RL12] Resends exhausted: report error, disconnect link
// [RL13] Byte 3 time expiry flushes inbound buffers
// [RL14] First good frame after return starts flush timer
// [RL15] Byte 4 sets data-set-ready wait time
// [RL16] Wait timer starts only on falling edge
// [RL17] Expiry: link inactive, programs stop, unit check
// [RL18] Byte 5 limits unacknowledged retransmissions
// [RL19] Limit exhausted: report error, disconnect link
// [RL20] Time bytes count units of 100 ms
// [RL21] Oversized field: discard, reject, disconnect, report
`timescale 1ns/1ps
module x25lp_core
    import x25lp_pkg::*;
#(
    parameter int UNIT_CYCLES = X25LP_UNIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pool_running,
    input wire logic dsr_pin,
    input x25lp_link_ev_t link_ev,
    output x25lp_link_act_t link_act
);
    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a < X25LP_A_LIMIT);
    endfunction

    logic acc, wr_ok, cmd_wr, branch_cmd, setmode_cmd, setmode_ok;
    logic [X25LP_ADDR_W-1:0] data_addr, next_ccw;
    logic [7:0] stage [X25LP_NPARAM];
    logic [7:0] prm [X25LP_NPARAM];
    logic [31:0] stage_w [4];
    logic [31:0] prm_w [4];
    logic [31:0] rd_word;
    logic [X25LP_STAT_W-1:0] status, stat_set, stat_clr;
    logic [X25LP_PRE_W-1:0] pre;
    logic tick;
    logic [X25LP_NTIMER-1:0] t_start, t_stop, t_run, t_exp;
    logic [7:0] t_load [X25LP_NTIMER];
    x25lp_resp_state_t rs;
    logic [7:0] exp_cnt, resend_cnt, ucnt;
    logic fac_done, cnt_done, give_up, unack_out;
    logic resend_cmd, frmr_disc, inb_flush, disc_pulse, stop_prog;
    logic dsr_s1, dsr_s2, dsr_d, dsr_fall, dsr_rise, dsr_lost;
    logic fresh, rx_good, oversize;
    logic [15:0] max_len;

    // APB: one access cycle; read data and error are sampled at setup.
    assign acc = psel & penable & pready;
    assign wr_ok = acc & pwrite & addr_ok(paddr);
    assign cmd_wr = wr_ok && (paddr == X25LP_A_CMD);
    assign branch_cmd = cmd_wr && (pwdata[7:0] == X25LP_OP_BRANCH);
    assign setmode_cmd = cmd_wr && (pwdata[7:0] == X25LP_OP_SETMODE);
    assign setmode_ok = setmode_cmd && pool_running
        && !pwdata[X25LP_CMD_CD_BIT]; // RL6

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            if (psel && !penable) begin
                pslverr <= ~addr_ok(paddr);
                prdata <= rd_word;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data_addr <= '0;
        end else if (wr_ok && paddr == X25LP_A_ADDR) begin
            data_addr <= pwdata[X25LP_ADDR_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            next_ccw <= '0;
        end else if (branch_cmd) begin
            next_ccw <= data_addr; // RL1
        end
    end

    for (genvar k = 0; k < X25LP_NPARAM; k++) begin : g_prm
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                stage[k] <= 8'h00;
            end else if (wr_ok
                && paddr == X25LP_A_STAGE + 8'(4 * (k / 4))) begin
                stage[k] <= pwdata[8 * (k % 4) +: 8];
            end
        end
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                prm[k] <= X25LP_PRM_RESET;
            end else if (setmode_ok) begin
                prm[k] <= stage[k]; // RL3 RL5
            end
        end
    end

    for (genvar w = 0; w < 4; w++) begin : g_pack
        for (genvar b = 0; b < 4; b++) begin : g_byte
            if (4 * w + b < X25LP_NPARAM) begin : g_used
                assign stage_w[w][8 * b +: 8] = stage[4 * w + b];
                assign prm_w[w][8 * b +: 8] = prm[4 * w + b];
            end else begin : g_pad
                assign stage_w[w][8 * b +: 8] = 8'h00;
                assign prm_w[w][8 * b +: 8] = 8'h00;
            end
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        if (paddr == X25LP_A_ADDR) begin
            rd_word = {8'h00, data_addr};
        end else if (paddr == X25LP_A_NEXT) begin
            rd_word = {8'h00, next_ccw};
        end else if (paddr == X25LP_A_STATUS) begin
            rd_word = {23'h000000, status};
        end else if (addr_ok(paddr) && paddr >= X25LP_A_ACTIVE) begin
            rd_word = prm_w[paddr[3:2]];
        end else if (addr_ok(paddr) && paddr >= X25LP_A_STAGE) begin
            rd_word = stage_w[paddr[3:2]];
        end
    end

    // Status: hardware set wins over a software write-one-to-clear.
    always_comb begin
        stat_set = '0;
        stat_set[X25LP_S_REJECT] = setmode_cmd & ~setmode_ok;
        stat_set[X25LP_S_LOADED] = setmode_ok;
        stat_set[X25LP_S_RESP_ERR] = give_up; // RL12
        stat_set[X25LP_S_UNACK_ERR] = unack_out; // RL19
        stat_set[X25LP_S_IFIELD_ERR] = oversize; // RL21
        stat_set[X25LP_S_UNIT_CHECK] = dsr_lost; // RL17
        stat_set[X25LP_S_INACTIVE] = dsr_lost; // RL17
        stat_set[X25LP_S_DISC] = give_up | unack_out;
        stat_set[X25LP_S_DONE] = cmd_wr;
        stat_clr = (wr_ok && paddr == X25LP_A_STATUS)
            ? pwdata[X25LP_STAT_W-1:0] : '0;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status <= '0;
        end else begin
            status <= (status & ~stat_clr) | stat_set;
        end
    end

    // Shared 100 ms tick for all timers.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pre <= '0;
            tick <= 1'b0;
        end else if (pre == X25LP_PRE_W'(UNIT_CYCLES - 1)) begin
            pre <= '0;
            tick <= 1'b1; // RL20
        end else begin
            pre <= pre + X25LP_PRE_W'(1);
            tick <= 1'b0;
        end
    end

    assign t_load[X25LP_T_RESP] = prm[X25LP_P_TP]; // RL7
    assign t_load[X25LP_T_INB] = prm[X25LP_P_INB]; // RL13
    assign t_load[X25LP_T_DSR] = prm[X25LP_P_DSR]; // RL15

    for (genvar i = 0; i < X25LP_NTIMER; i++) begin : g_tmr
        x25lp_timer u_timer (
            .core_clk(core_clk),
            .rst(rst),
            .start(t_start[i]),
            .stop(t_stop[i]),
            .tick(tick),
            .load(t_load[i]),
            .running(t_run[i]),
            .expire(t_exp[i])
        );
    end

    // Response timer: expiries per resend, then resends before giving up.
    assign fac_done = ({1'b0, exp_cnt} + 9'h001)
        >= {1'b0, prm[X25LP_P_FP]}; // RL10
    assign cnt_done = resend_cnt >= prm[X25LP_P_CP]; // RL11
    assign give_up = (rs == X25LP_RS_WAIT) && t_exp[X25LP_T_RESP]
        && !link_ev.rx_response && !link_ev.tx_poll_sent
        && fac_done && cnt_done;
    assign t_start[X25LP_T_RESP] = link_ev.tx_poll_sent // RL8
        | ((rs == X25LP_RS_WAIT) & t_exp[X25LP_T_RESP]
        & ~link_ev.rx_response & ~(fac_done & cnt_done)); // RL9
    assign t_stop[X25LP_T_RESP] = link_ev.rx_response;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rs <= X25LP_RS_IDLE;
            exp_cnt <= 8'h00;
            resend_cnt <= 8'h00;
            resend_cmd <= 1'b0;
        end else begin
            resend_cmd <= 1'b0;
            case (rs)
                X25LP_RS_IDLE: begin
                    if (link_ev.tx_poll_sent && !link_ev.rx_response) begin
                        exp_cnt <= 8'h00;
                        resend_cnt <= 8'h00;
                        rs <= X25LP_RS_WAIT;
                    end
                end
                X25LP_RS_WAIT: begin
                    if (link_ev.rx_response) begin
                        rs <= X25LP_RS_IDLE;
                    end else if (link_ev.tx_poll_sent) begin
                        rs <= X25LP_RS_WAIT;
                    end else if (t_exp[X25LP_T_RESP]) begin
                        if (!fac_done) begin
                            exp_cnt <= exp_cnt + 8'h01; // RL9
                        end else if (!cnt_done) begin
                            exp_cnt <= 8'h00;
                            resend_cnt <= resend_cnt + 8'h01;
                            resend_cmd <= 1'b1; // RL9
                        end else begin
                            rs <= X25LP_RS_IDLE; // RL12
                        end
                    end
                end
                default: rs <= X25LP_RS_IDLE;
            endcase
        end
    end

    // Unacknowledged retransmission limit.
    assign unack_out = link_ev.iframe_resent && !link_ev.rx_ack
        && ucnt >= prm[X25LP_P_N2]; // RL18
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ucnt <= 8'h00;
        end else if (link_ev.rx_ack || unack_out) begin
            ucnt <= 8'h00;
        end else if (link_ev.iframe_resent) begin
            ucnt <= ucnt + 8'h01;
        end
    end

    // Inbound traffic timer and information field size check.
    assign max_len = {prm[X25LP_P_MAXH], prm[X25LP_P_MAXL]};
    assign oversize = link_ev.rx_frame_ok
        && link_ev.rx_ifield_len > max_len; // RL21
    assign rx_good = link_ev.rx_frame_ok && !oversize;
    assign t_start[X25LP_T_INB] = rx_good & fresh; // RL14
    assign t_stop[X25LP_T_INB] = link_ev.bufs_returned;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fresh <= 1'b1;
        end else if (link_ev.bufs_returned) begin
            fresh <= 1'b1;
        end else if (rx_good) begin
            fresh <= 1'b0;
        end
    end

    // Data set ready passes two flip-flops before any edge detection.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dsr_s1 <= 1'b0;
            dsr_s2 <= 1'b0;
            dsr_d <= 1'b0;
        end else begin
            dsr_s1 <= dsr_pin;
            dsr_s2 <= dsr_s1;
            dsr_d <= dsr_s2;
        end
    end
    assign dsr_fall = dsr_d & ~dsr_s2;
    assign dsr_rise = ~dsr_d & dsr_s2;
    assign t_start[X25LP_T_DSR] = dsr_fall; // RL16
    assign t_stop[X25LP_T_DSR] = dsr_rise;
    assign dsr_lost = t_exp[X25LP_T_DSR] & ~dsr_s2; // RL17

    // Link actions are registered one-cycle pulses, except link_inactive, which follows its status bit.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frmr_disc <= 1'b0;
            inb_flush <= 1'b0;
            disc_pulse <= 1'b0;
            stop_prog <= 1'b0;
        end else begin
            frmr_disc <= oversize; // RL21
            inb_flush <= t_exp[X25LP_T_INB]; // RL13
            disc_pulse <= give_up | unack_out; // RL12 RL19
            stop_prog <= dsr_lost; // RL17
        end
    end

    assign link_act = '{resend_cmd: resend_cmd, send_frmr_disc: frmr_disc,
        inbound_flush: inb_flush, link_disconnect: disc_pulse,
        link_inactive: status[X25LP_S_INACTIVE], stop_programs: stop_prog};

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_poll_start;
        link_ev.tx_poll_sent ##1 t_run[X25LP_T_RESP];
    endsequence

    chk_branch_target: assert property ( // RL1
        branch_cmd |=> next_ccw == $past(data_addr))
        else $error("branch did not load next command word address");
    chk_setmode_reject: assert property ( // RL6
        (setmode_cmd && !setmode_ok) |=> status[X25LP_S_REJECT]
        && prm[X25LP_P_TP] == $past(prm[X25LP_P_TP]))
        else $error("rejected load changed parameters or was not flagged");
    chk_setmode_load: assert property ( // RL3
        setmode_ok |=> prm[X25LP_P_N2] == $past(stage[X25LP_P_N2])
        && prm[12] == $past(stage[12]))
        else $error("accepted load did not copy parameter bytes");
    chk_resp_start: assert property ( // RL8
        link_ev.tx_poll_sent |-> s_poll_start)
        else $error("response timer not running after poll frame");
    chk_resend_cause: assert property ( // RL9
        resend_cmd |-> $past(t_exp[X25LP_T_RESP]) && t_run[X25LP_T_RESP])
        else $error("resend without response timer expiry");
    chk_give_up: assert property ( // RL12
        give_up |=> link_act.link_disconnect && status[X25LP_S_RESP_ERR]
        && rs == X25LP_RS_IDLE)
        else $error("exhausted resends did not disconnect");
    chk_unack_out: assert property ( // RL19
        unack_out |=> link_act.link_disconnect && ucnt == 8'h00
        && status[X25LP_S_UNACK_ERR])
        else $error("retransmission limit did not disconnect");
    chk_dsr_start: assert property ( // RL16
        $fell(dsr_s2) |=> t_run[X25LP_T_DSR])
        else $error("data set ready wait timer did not start");
    chk_dsr_lost: assert property ( // RL17
        dsr_lost |=> link_act.stop_programs && link_act.link_inactive
        && status[X25LP_S_UNIT_CHECK])
        else $error("lost data set ready did not stop programs");
    chk_oversize: assert property ( // RL21
        oversize |-> !t_start[X25LP_T_INB] ##1 link_act.send_frmr_disc)
        else $error("oversized field not rejected");
endmodule // x25lp_core

// [tb/x25lp_link_model.sv]
// Purpose: Line side model that raises frame events and drives the DSR pin.
// Assumes: Events are one-cycle pulses on core_clk.
// Notes: A resend request comes back as a new poll frame on the line.
`timescale 1ns/1ps
module x25lp_link_model
    import x25lp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input x25lp_link_act_t link_act,
    output x25lp_link_ev_t link_ev,
    output logic dsr_pin
);
    x25lp_link_ev_t man;
    logic echo;
    initial begin
        man = '0;
        dsr_pin = 1'b0;
    end
    // The resent command frame shows up again as a poll on the line.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            echo <= 1'b0;
        end else begin
            echo <= link_act.resend_cmd;
        end
    end
    always_comb begin
        link_ev = man;
        link_ev.tx_poll_sent = man.tx_poll_sent | echo;
    end
    // The length is not valid outside its frame, so it is inverted there.
    task automatic ev(input x25lp_link_ev_t e);
        @(posedge core_clk);
        man <= e;
        @(posedge core_clk);
        man <= x25lp_link_ev_t'({6'h00, ~e.rx_ifield_len});
    endtask
    task automatic set_dsr(input logic v);
        @(posedge core_clk);
        dsr_pin <= v;
    endtask
endmodule // x25lp_link_model

// [tb/tb_x25_link_parameter_timers.sv]
// Purpose: Self-checking bench for the link parameter timers over APB.
// Assumes: UNIT_CYCLES is 4, so one time unit is four clocks.
// Notes: Time windows allow one unit of tick phase and the DSR sync delay.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
    $display("mismatch %s exp %h got %h", nm, ex, gt); err_count++; end end
module tb_x25_link_parameter_timers
    import x25lp_pkg::*;
;
    localparam int B_RESEND = 5;
    localparam int B_FRMR = 4;
    localparam int B_FLUSH = 3;
    localparam int B_DISC = 2;
    localparam int B_STOP = 0;
    logic core_clk, rst, psel, penable, pwrite, pool_running, dsr_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr;
    x25lp_link_ev_t link_ev;
    x25lp_link_act_t link_act;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    logic [31:0] r;
    logic e;

    x25lp_core #(.UNIT_CYCLES(4)) DUT (.core_clk(core_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pool_running(pool_running), .dsr_pin(dsr_pin),
        .link_ev(link_ev), .link_act(link_act));
    x25lp_link_model m (.core_clk(core_clk), .rst(rst),
        .link_act(link_act), .link_ev(link_ev), .dsr_pin(dsr_pin));

    task automatic stop_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] rd, output logic er);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rr;
        logic ee;
        apb(1'b1, a, d, rr, ee);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
            input logic [31:0] mk, input logic [31:0] x);
        logic [31:0] rr;
        logic ee;
        apb(1'b0, a, 32'h0, rr, ee);
        `CHK(nm, x, rr & mk)
    endtask
    task automatic wait_act(input int b, input int lim, output int k);
        logic [5:0] v;
        k = 0;
        // Look past the edge so a pulse launched at it is seen.
        #1;
        v = link_act;
        while (v[b] !== 1'b1 && k < lim) begin
            @(posedge core_clk);
            #1;
            v = link_act;
            k++;
        end
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pool_running = 1'b0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        rdc("status", X25LP_A_STATUS, 32'h1ff, 32'h0);
        rdc("active0", X25LP_A_ACTIVE, 32'hffffffff, 32'h01010101);
        apb(1'b0, X25LP_A_LIMIT, 32'h0, r, e);
        `CHK("slverr", 1'b1, e)
        wr(X25LP_A_STAGE, 32'h03010202);
        wr(X25LP_A_STAGE + 8'h04, 32'h10000202);
        wr(X25LP_A_CMD, {24'h0, X25LP_OP_SETMODE});
        rdc("nopool", X25LP_A_STATUS, 32'h3, 32'h1);
        wr(X25LP_A_STATUS, 32'h1ff);
        pool_running <= 1'b1;
        wr(X25LP_A_CMD, {23'h0, 1'b1, X25LP_OP_SETMODE});
        rdc("cdflag", X25LP_A_STATUS, 32'h3, 32'h1);
        rdc("kept", X25LP_A_ACTIVE, 32'hffffffff, 32'h01010101);
        wr(X25LP_A_STATUS, 32'h1ff);
        wr(X25LP_A_CMD, {24'h0, X25LP_OP_SETMODE});
        rdc("loaded", X25LP_A_STATUS, 32'h3, 32'h2);
        rdc("act0", X25LP_A_ACTIVE, 32'hffffffff, 32'h03010202);
        rdc("act1", X25LP_A_ACTIVE + 8'h04, 32'hffffffff, 32'h10000202);
        rdc("act3", X25LP_A_ACTIVE + 8'h0c, 32'hff, 32'h00);
        wr(X25LP_A_STAGE, 32'hffffffff);
        rdc("held", X25LP_A_ACTIVE, 32'hffffffff, 32'h03010202);
        wr(X25LP_A_ADDR, 32'h00000040);
        wr(X25LP_A_CMD, {24'h0, X25LP_OP_BRANCH});
        rdc("next", X25LP_A_NEXT, 32'hffffff, 32'h40);
        m.ev(x25lp_link_ev_t'(22'h200000));
        m.ev(x25lp_link_ev_t'(22'h100000));
        wait_act(B_RESEND, 40, n);
        `CHK("answered", 40, n)
        m.ev(x25lp_link_ev_t'(22'h200000));
        wait_act(B_RESEND, 40, n);
        `CHK("resend", 1'b1, n >= 14 && n <= 17)
        wait_act(B_DISC, 40, n);
        `CHK("cp out", 1'b1, n >= 15 && n <= 30)
        rdc("resp err", X25LP_A_STATUS, 32'h84, 32'h84);
        wr(X25LP_A_STATUS, 32'h1ff);
        m.ev(x25lp_link_ev_t'(22'h010000));
        m.ev(x25lp_link_ev_t'(22'h020005));
        wait_act(B_FLUSH, 40, n);
        `CHK("flush", 1'b1, n >= 10 && n <= 13)
        m.ev(x25lp_link_ev_t'(22'h080000));
        m.ev(x25lp_link_ev_t'(22'h080000));
        wait_act(B_DISC, 4, n);
        `CHK("n2 early", 4, n)
        m.ev(x25lp_link_ev_t'(22'h080000));
        wait_act(B_DISC, 4, n);
        `CHK("n2 out", 1'b1, n < 4)
        rdc("unack err", X25LP_A_STATUS, 32'h88, 32'h88);
        m.ev(x25lp_link_ev_t'(22'h020010));
        wait_act(B_FRMR, 4, n);
        `CHK("max ok", 4, n)
        m.ev(x25lp_link_ev_t'(22'h020011));
        wait_act(B_FRMR, 4, n);
        `CHK("oversize", 1'b1, n < 4)
        rdc("if err", X25LP_A_STATUS, 32'h10, 32'h10);
        wr(X25LP_A_STATUS, 32'h1ff);
        m.set_dsr(1'b1);
        repeat (4) @(posedge core_clk);
        m.set_dsr(1'b0);
        wait_act(B_STOP, 40, n);
        `CHK("dsr wait", 1'b1, n >= 9 && n <= 12)
        `CHK("inactive", 1'b1, link_act.link_inactive)
        rdc("unit chk", X25LP_A_STATUS, 32'h60, 32'h60);
        stop_test();
    end
endmodule // tb_x25_link_parameter_timers
